// *** shared/asrr_pkg.sv ***
// constants shared by the serial result reader host controller
package asrr_pkg;
  // clock and link timing
  localparam int unsigned MCLK_PERIOD_NS = 25;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned SCLK_HIGH_MIN_NS = 110;
  localparam int unsigned SCLK_MAX_MHZ_FS = 10;
  localparam int unsigned SCLK_SLOW_PERIOD_NS = 250;
  // high time rounds up, plus the data synchroniser latency so the sample sees settled data
  localparam int unsigned SCLK_HIGH_CYC =
    (SCLK_HIGH_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS + SYNC_STAGES;
  // period strictly longer than the slow-variant limit
  localparam int unsigned SCLK_PERIOD_CYC = SCLK_SLOW_PERIOD_NS / MCLK_PERIOD_NS + 1;
  localparam int unsigned SCLK_LOW_CYC =
    (SCLK_PERIOD_CYC > SCLK_HIGH_CYC) ? SCLK_PERIOD_CYC - SCLK_HIGH_CYC : 1;
  localparam int unsigned CONVERSION_START_N_LOW_CYC_DEF = 4;
  // frame layout
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned RESULT_BITS = 12;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_RAW = 8'h0C;
  // control fields
  localparam int unsigned CTRL_START_CONV = 0;
  localparam int unsigned CTRL_READ_NOW = 1;
  localparam int unsigned CTRL_AUTO_READ = 2;
  localparam int unsigned CTRL_ALLOW_BUSY = 3;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // status fields
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_READING = 1;
  localparam int unsigned ST_VALID = 2;
  localparam int unsigned ST_FRAME_ERR = 3;
  localparam int unsigned ST_ARMED = 4;
  localparam int unsigned ST_CONVERTING = 5;
  // link states
  typedef enum logic [2:0] {S_IDLE, S_CONV, S_SETUP, S_HIGH, S_LOW} asrr_state_t;
endpackage

// *** logic/asrr_sync.sv ***
// two flip-flop synchroniser for signals from outside the clock domain
`timescale 1ns/10ps
module asrr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // asrr_sync

// *** logic/asrr_host.sv ***
// host controller: reads the converter result word over a gated serial clock
// How it works
// RULE1 - master, clock idles low, samples falling
// RULE2 - select bit ANDed with serial clock
// RULE3 - busy status polled before read
// RULE4 - busy falling edge may launch read
// RULE5 - active-high frame sync gates serial clock
// RULE6 - exactly sixteen pulses, clock low between
// RULE7 - clock high time at least 110 ns
// RULE8 - three leading zeros still accepted
// RULE9 - clock below 4 MHz for slow variant
// RULE10 - clock never above 10 MHz
// RULE11 - sixteen-bit word length per read
// RULE12 - first bit sampled on first falling edge
// RULE13 - read only after conversion has finished; with CTRL_ALLOW_BUSY set a read order is taken while busy is high
// RULE14 - avoid reading during conversion
// RULE15 - converter sends four zeros, result MSB first
// RULE16 - converter changes data on falling edges
// RULE17 - no conversion start during a read
// RULE18 - clock held low between transfers
// RULE19 - assemble MSB first, strobe 12-bit result
// RULE20 - busy input synchronised before use
`timescale 1ns/10ps
module asrr_host
  import asrr_pkg::*;
#(
  parameter int CONVERSION_START_N_LOW_CYC = CONVERSION_START_N_LOW_CYC_DEF
) (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic HOST_SERIAL_CLOCK,
  output logic RECEIVE_FRAME_SYNC,
  output logic HOST_PORT_PIN,
  output logic CONVERSION_START_N,
  input wire logic SERIAL_RESULT_OUT,
  input wire logic CONVERTER_BUSY,
  output logic [RESULT_BITS-1:0] RESULT,
  output logic RESULT_VALID
);
  initial begin
    if (CONVERSION_START_N_LOW_CYC < 1 || CONVERSION_START_N_LOW_CYC > 255) $error("conversion start width out of range");
    if (SCLK_HIGH_CYC > 15 || SCLK_LOW_CYC > 15) $error("serial clock phase count too wide");
  end

  asrr_state_t state_q;
  logic busy_s, data_s, busy_prev_q;
  logic [3:0] phase_q;
  logic [4:0] bit_q;
  logic [7:0] conv_cnt_q;
  logic [FRAME_BITS-1:0] shift_q, raw_q;
  logic sclk_q, select_q;
  logic auto_q, allow_q, armed_q, valid_q, ferr_q;
  logic wr_ctrl, rd_access, rd_result, busy_fell, start_conv, read_req, frame_done;

  // pin inputs cross into the MCLK domain first
  asrr_sync #(.WIDTH(2)) u_sync (
    .clk(MCLK),
    .rst(RESET),
    .async_in({CONVERTER_BUSY, SERIAL_RESULT_OUT}),
    .sync_out({busy_s, data_s})
  ); // RULE20

  // apb decode: zero wait states
  assign PREADY = 1'b1;
  assign wr_ctrl = PSEL && PENABLE && PWRITE && (PADDR == OFS_CTRL);
  assign rd_access = PSEL && PENABLE && !PWRITE;
  assign rd_result = rd_access && (PADDR == OFS_RESULT);
  assign PSLVERR = PSEL && PENABLE &&
    !(PADDR == OFS_CTRL || PADDR == OFS_STATUS || PADDR == OFS_RESULT || PADDR == OFS_RAW);

  // command decode; commands outside idle are dropped
  assign start_conv = wr_ctrl && PWDATA[CTRL_START_CONV] && state_q == S_IDLE; // RULE17
  assign busy_fell = busy_prev_q && !busy_s;
  // a read order is refused while busy is high unless software allows reading during conversion
  assign read_req = state_q == S_IDLE && !start_conv &&
    ((wr_ctrl && PWDATA[CTRL_READ_NOW] && (!busy_s || allow_q)) || // RULE3 RULE13 RULE14
     (armed_q && busy_fell)); // RULE4
  assign frame_done = state_q == S_LOW && phase_q == 4'(SCLK_LOW_CYC - 1) &&
    bit_q == 5'(FRAME_BITS);

  // control register
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      {allow_q, auto_q} <= CTRL_RESET;
    end else if (wr_ctrl) begin
      auto_q <= PWDATA[CTRL_AUTO_READ];
      allow_q <= PWDATA[CTRL_ALLOW_BUSY];
    end
  end

  // busy edge history from the synchronised copy only
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) busy_prev_q <= 1'b0;
    else busy_prev_q <= busy_s;
  end

  // auto-read arms on a conversion start and fires on the end-of-conversion edge
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) armed_q <= 1'b0;
    else if (start_conv) armed_q <= auto_q;
    else if (read_req || (wr_ctrl && !PWDATA[CTRL_AUTO_READ])) armed_q <= 1'b0;
  end

  // link sequencer: conversion pulse, then gated clock frame of sixteen pulses
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      state_q <= S_IDLE;
      phase_q <= 4'h0;
      bit_q <= 5'h00;
      conv_cnt_q <= 8'h00;
      sclk_q <= 1'b0;
      select_q <= 1'b0;
      shift_q <= '0;
    end else begin
      case (state_q)
        S_IDLE: begin
          sclk_q <= 1'b0; // RULE18
          if (start_conv) begin
            conv_cnt_q <= 8'h00;
            state_q <= S_CONV;
          end else if (read_req) begin
            select_q <= 1'b1; // RULE2 RULE5
            bit_q <= 5'h00;
            state_q <= S_SETUP;
          end
        end
        S_CONV: begin
          conv_cnt_q <= conv_cnt_q + 8'h01;
          if (conv_cnt_q == 8'(CONVERSION_START_N_LOW_CYC - 1)) state_q <= S_IDLE;
        end
        // one cycle of select with the clock still low before the first rise
        S_SETUP: begin
          sclk_q <= 1'b1; // RULE1
          phase_q <= 4'h0;
          state_q <= S_HIGH;
        end
        S_HIGH: begin
          phase_q <= phase_q + 4'h1;
          if (phase_q == 4'(SCLK_HIGH_CYC - 1)) begin // RULE7 RULE9 RULE10
            sclk_q <= 1'b0;
            shift_q <= {shift_q[FRAME_BITS-2:0], data_s}; // RULE12 RULE16
            bit_q <= bit_q + 5'h01;
            phase_q <= 4'h0;
            state_q <= S_LOW;
          end
        end
        S_LOW: begin
          phase_q <= phase_q + 4'h1;
          if (phase_q == 4'(SCLK_LOW_CYC - 1)) begin
            phase_q <= 4'h0;
            if (bit_q == 5'(FRAME_BITS)) begin // RULE6 RULE11
              select_q <= 1'b0;
              state_q <= S_IDLE;
            end else begin
              sclk_q <= 1'b1;
              state_q <= S_HIGH;
            end
          end
        end
        default: begin
          sclk_q <= 1'b0;
          select_q <= 1'b0;
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // result capture; leading zeros dropped from RESULT, raw_q keeps the whole sixteen-bit word
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      raw_q <= '0;
      RESULT <= '0;
      RESULT_VALID <= 1'b0;
      ferr_q <= 1'b0;
    end else begin
      RESULT_VALID <= frame_done; // RULE19
      if (frame_done) begin
        raw_q <= shift_q;
        RESULT <= shift_q[RESULT_BITS-1:0]; // RULE15
        // top bit may be lost by a late first sample, so only three zeros are checked
        ferr_q <= |shift_q[FRAME_BITS-2:RESULT_BITS]; // RULE8
      end
    end
  end

  // valid flag: a new result wins over a same-cycle read that clears it
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) valid_q <= 1'b0;
    else if (frame_done) valid_q <= 1'b1;
    else if (rd_result) valid_q <= 1'b0;
  end

  // read data registered in the setup cycle, held through the access cycle
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE) begin
      PRDATA <= 32'h0000_0000;
      case (PADDR)
        OFS_CTRL: PRDATA[3:0] <= {allow_q, auto_q, 2'h0};
        OFS_STATUS: PRDATA[5:0] <= {state_q == S_CONV, armed_q, ferr_q, valid_q,
          state_q == S_SETUP || state_q == S_HIGH || state_q == S_LOW, busy_s};
        OFS_RESULT: PRDATA[RESULT_BITS-1:0] <= RESULT;
        OFS_RAW: PRDATA[FRAME_BITS-1:0] <= raw_q;
        default: PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // pins: clock gated by the select bit, which doubles as the frame sync
  assign HOST_SERIAL_CLOCK = sclk_q & select_q; // RULE2 RULE5
  assign HOST_PORT_PIN = select_q;
  assign RECEIVE_FRAME_SYNC = select_q;
  assign CONVERSION_START_N = !(state_q == S_CONV); // RULE17

  // helper counters for the checks below
  logic [4:0] pulse_cnt_q;
  logic [3:0] hi_cnt_q, lo_cnt_q;
  logic busy_d1_q;
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      pulse_cnt_q <= 5'h00;
      hi_cnt_q <= 4'h0;
      lo_cnt_q <= 4'h0;
      busy_d1_q <= 1'b0;
    end else begin
      busy_d1_q <= CONVERTER_BUSY;
      if (state_q == S_SETUP) pulse_cnt_q <= 5'h00;
      else if (HOST_SERIAL_CLOCK && !$past(HOST_SERIAL_CLOCK)) pulse_cnt_q <= pulse_cnt_q + 5'h01;
      hi_cnt_q <= HOST_SERIAL_CLOCK ? hi_cnt_q + 4'h1 : 4'h0;
      lo_cnt_q <= (!sclk_q && select_q) ? lo_cnt_q + 4'h1 : 4'h0;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  a_idle_clock_low: assert property (!select_q |-> !HOST_SERIAL_CLOCK) // RULE18
    else $error("serial clock active while deselected");
  a_sixteen_pulses: assert property ($fell(select_q) |-> pulse_cnt_q == 5'h10) // RULE6
    else $error("frame did not carry sixteen clock pulses");
  // the counter already holds every high sample when the fall is seen
  a_high_time: assert property ($fell(HOST_SERIAL_CLOCK) |-> hi_cnt_q == 4'(SCLK_HIGH_CYC)) // RULE7
    else $error("serial clock high time wrong");
  // the first rise follows the one-cycle setup, so only rises after a bit are timed
  a_low_time: assert property ($rose(sclk_q) && bit_q != 5'h00
      |-> lo_cnt_q == 4'(SCLK_LOW_CYC)) // RULE9
    else $error("serial clock low time wrong");
  a_no_conv_read: assert property ($fell(CONVERSION_START_N) |-> !select_q && !HOST_SERIAL_CLOCK) // RULE17
    else $error("conversion started during a read");
  a_conv_width: assert property ($fell(CONVERSION_START_N)
      |-> !CONVERSION_START_N[*4] ##1 CONVERSION_START_N) // RULE17
    else $error("conversion start pulse width wrong");
  a_sample_fall: assert property ($fell(HOST_SERIAL_CLOCK) |-> shift_q[0] == $past(data_s)) // RULE12
    else $error("data not sampled at falling edge");
  a_read_not_busy: assert property ($rose(select_q) && !$past(allow_q) && !$past(armed_q)
      |-> !$past(busy_s)) // RULE13
    else $error("read launched while converter busy");
  a_result_strobe: assert property (RESULT_VALID |-> RESULT == raw_q[11:0] && !select_q
      ##1 !RESULT_VALID) // RULE19
    else $error("result strobe or data wrong");
  a_frame_check: assert property (RESULT_VALID |-> ferr_q == (raw_q[14:12] != 3'h0)) // RULE8
    else $error("frame error flag wrong");
  a_busy_sync: assert property (##2 busy_s == $past(busy_d1_q)) // RULE20
    else $error("busy synchroniser latency wrong");
  a_auto_read: assert property (armed_q && busy_fell && state_q == S_IDLE && !wr_ctrl
      |=> state_q == S_SETUP) // RULE4
    else $error("end of conversion did not launch a read");

  c_read_done: cover property (RESULT_VALID);
  c_conv_then_auto: cover property ($fell(CONVERSION_START_N) ##[1:1000] $rose(select_q));
  c_frame_err: cover property (RESULT_VALID && ferr_q);
  c_valid_race: cover property (frame_done && rd_result);
endmodule // asrr_host

// *** tb/asrr_conv_model.sv ***
// behavioural model of the converter on the far side of the serial link
`timescale 1ns/10ps
module asrr_conv_model #(
  // off the clock grid so the end of busy never lands on a sampling edge
  parameter int CONV_NS = 2010
) (
  input wire logic sclk,
  input wire logic conversion_start_n_n,
  input wire logic [11:0] value,
  output logic busy,
  output logic serial_result_out
);
  logic [15:0] word;
  int cnt;
  assign word = {4'h0, value};
  initial begin
    busy = 1'b0;
    serial_result_out = 1'b1;
    cnt = 0;
  end
  // counter clears only with the clock low; busy stands for the conversion time
  always @(negedge conversion_start_n_n) begin
    if (!sclk) cnt = 0;
    busy = 1'b1;
    #(CONV_NS);
    busy = 1'b0;
  end
  // first bit leaves on the first rise; extra clocks restart the word
  always @(posedge sclk) begin
    if (cnt == 0 || cnt >= 16) begin
      cnt = 0;
      serial_result_out = word[15];
    end
  end
  // data moves on falling edges; after the last one the line floats, shown as inverse
  always @(negedge sclk) begin
    cnt = cnt + 1;
    if (cnt < 16) serial_result_out = word[15-cnt];
    else serial_result_out = ~serial_result_out;
  end
endmodule // asrr_conv_model

// *** tb/testbench.sv ***
// self-checking bench for the serial result reader host controller
`timescale 1ns/10ps
module testbench;
  import asrr_pkg::*;
  logic mclk, reset, psel, penable, pwrite, rerr, sclk, rfs, pin, cs_n, serial_result_out, busy, vld;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic pready, pslverr;
  logic [11:0] val, res;
  logic [11:0] vals [3] = '{12'hFFF, 12'h001, 12'h5A3};
  int bad_count = 0;
  int num_checks = 0;
  int hi = 0;
  int per = 0;
  int pulses = 0;
  logic sclk_d = 1'b0;
  logic pin_d = 1'b0;
  asrr_host i_dut (.MCLK(mclk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .HOST_SERIAL_CLOCK(sclk), .RECEIVE_FRAME_SYNC(rfs),
    .HOST_PORT_PIN(pin), .CONVERSION_START_N(cs_n), .SERIAL_RESULT_OUT(serial_result_out),
    .CONVERTER_BUSY(busy), .RESULT(res), .RESULT_VALID(vld));
  asrr_conv_model i_conv (.sclk(sclk), .conversion_start_n_n(cs_n), .value(val), .busy(busy),
    .serial_result_out(serial_result_out));
  // 40 MHz system clock
  always #12.5 mclk = ~mclk;
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tmo(input string nm);
    bad_count++;
    $display("mismatch %s expected response seen timeout", nm);
    close_out();
  endtask
  // one apb transfer; result lands in rdat and rerr, one idle edge after release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) tmo("pready");
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wait_valid();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (vld !== 1'b1 && n < 3000);
    if (n >= 3000) tmo("result_valid");
    @(posedge mclk);
    check("valid_pulse", vld, 1'b0);
  endtask
  // watch the link wires: gating, pulse count, high time and period
  always @(posedge mclk) begin
    if (!reset) begin
      per = per + 1;
      if (sclk) hi = hi + 1;
      if (sclk) check("clock_gate", pin & rfs, 1'b1);
      if (!cs_n) check("conv_idle", pin, 1'b0);
      if (sclk && !sclk_d) begin
        if (pulses > 0) check("period", per > 10, 1'b1);
        per = 0;
        pulses = pulses + 1;
      end
      if (!sclk && sclk_d) begin
        check("high_time", hi >= 5, 1'b1);
        hi = 0;
      end
      if (pin_d && !pin) begin
        check("pulses", pulses, 16);
        pulses = 0;
      end
    end
    sclk_d = sclk;
    pin_d = pin;
  end
  // main sequence
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    val = 12'hA5C;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    check("sclk_idle", sclk, 1'b0);
    check("conversion_start_n_idle", cs_n, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("status_rst", rdat, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped_err", rerr, 1'b1);
    check("unmapped_data", rdat, 32'h0);
    $display("test reset done");
    // polling flow; an early read order is refused while converting
    apb(1'b1, OFS_CTRL, 32'h1 << CTRL_START_CONV);
    repeat (6) @(posedge mclk);
    apb(1'b1, OFS_CTRL, 32'h1 << CTRL_READ_NOW);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("busy_seen", rdat[ST_BUSY], 1'b1);
    check("no_early_read", rdat[ST_READING], 1'b0);
    for (int i = 0; i < 200 && rdat[ST_BUSY] !== 1'b0; i++) apb(1'b0, OFS_STATUS, 32'h0);
    if (rdat[ST_BUSY] !== 1'b0) tmo("busy_poll");
    apb(1'b1, OFS_CTRL, 32'h1 << CTRL_READ_NOW);
    wait_valid();
    check("result_pin", res, 12'hA5C);
    apb(1'b0, OFS_RAW, 32'h0);
    check("raw_word", rdat, 32'h00000A5C);
    apb(1'b0, OFS_RESULT, 32'h0);
    check("result_reg", rdat, 32'h00000A5C);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("valid_cleared", rdat[ST_VALID], 1'b0);
    $display("test poll done");
    // interrupt style: busy falling edge launches the read, boundary values
    // arming takes the auto-read bit that stands when the conversion order arrives
    apb(1'b1, OFS_CTRL, 32'h1 << CTRL_AUTO_READ);
    apb(1'b0, OFS_CTRL, 32'h0);
    check("ctrl_readback", rdat, 32'h1 << CTRL_AUTO_READ);
    foreach (vals[i]) begin
      val = vals[i];
      apb(1'b1, OFS_CTRL, (32'h1 << CTRL_AUTO_READ) | (32'h1 << CTRL_START_CONV));
      wait_valid();
      check("auto_result", res, vals[i]);
    end
    $display("test auto read done");
    // conversion order in mid-frame must be ignored
    apb(1'b1, OFS_CTRL, (32'h1 << CTRL_READ_NOW) | (32'h1 << CTRL_ALLOW_BUSY));
    repeat (30) @(posedge mclk);
    apb(1'b1, OFS_CTRL, 32'h1 << CTRL_START_CONV);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("conv_refused", rdat[ST_CONVERTING], 1'b0);
    wait_valid();
    check("reread", res, 12'h5A3);
    $display("test overlap done");
    close_out();
  end
endmodule // testbench
